// ---- logic/ump_pkg.sv ----
// package: register map, bit positions and reset values of the serial port block
`default_nettype none
package ump_pkg;
    // register addresses on the special-function bus
    localparam logic [7:0] ADDR_CTRL = 8'h98;
    localparam logic [7:0] ADDR_DATA = 8'h99;
    localparam logic [7:0] ADDR_FMT = 8'ha9;
    // serial_port_control bit positions
    localparam int B_OVR = 7;
    localparam int B_PERR = 6;
    localparam int B_THRE = 5;
    localparam int B_REN = 4;
    localparam int B_TBX = 3;
    localparam int B_RBX = 2;
    localparam int B_TI = 1;
    localparam int B_RI = 0;
    // serial_format_control bit positions
    localparam int F_MCE = 7;
    localparam int F_PT_LO = 5;
    localparam int F_PE = 4;
    localparam int F_DL_LO = 2;
    localparam int F_XBE = 1;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h20;
    localparam logic [7:0] FMT_RESET = 8'h0c;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // software-writable bits of the control register (holding-empty is read only)
    localparam logic [7:0] CTRL_WMASK = 8'hdf;
    // parity type codes
    localparam logic [1:0] PT_ODD = 2'h0;
    localparam logic [1:0] PT_EVEN = 2'h1;
    localparam logic [1:0] PT_MARK = 2'h2;
    localparam logic [1:0] PT_SPACE = 2'h3;
    // receive buffer
    localparam int RX_DEPTH = 3;
    localparam int RX_WIDTH = 10;
endpackage
`default_nettype wire

// ---- logic/ump_uart.sv ----
// receive buffer and status/control register logic of the multiprocessor serial port
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1: master marks address bytes with extra bit one
// RQ2: multiproc mode: only extra-bit-one bytes raise receive flag
// RQ3: matched slave clears multiproc mode, resets afterwards
// RQ4: full receive buffer drops byte, sets overrun
// RQ5: bad parity on oldest byte sets sticky error
// RQ6: holding-empty bit reads one when write allowed
// RQ7: receive enable gates new bytes, buffer stays readable
// RQ8: extra-bit mode sends tx_extra_bit, parity overrides
// RQ9: rx_extra_bit shows extra bit or first stop
// RQ10: tx_done_flag set at start of stop bit
// RQ11: rx_avail_flag set at stop-bit sampling instant
// RQ12: rx_avail_flag held while buffer holds bytes
// RQ13: either flag with interrupt enabled requests interrupt
// RQ14: control register at 0x98, bit addressable
// RQ15: store byte only if room and stops high
// RQ16: data read returns oldest byte, frees slot
// RQ17: multiproc mode also needs extra bit enabled
// RQ18: software writes load flag bits directly

module ump_fifo #(
    parameter int WIDTH = ump_pkg::RX_WIDTH,
    parameter int DEPTH = ump_pkg::RX_DEPTH
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // refuse sizes the pointer logic cannot serve
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
        $error("ump_fifo: depth and width must be at least one");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] count;
    } ump_fifo_s;

    ump_fifo_s s_q, s_d;
    logic push, pop;

    assign inReady = (s_q.count != CW'(DEPTH));
    assign outValid = (s_q.count != '0);
    assign outData = s_q.mem[s_q.rd];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // pointer wrap by compare, since depth need not be a power of two
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = inData;
            s_d.wr = (s_q.wr == PW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == PW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
        end
        s_d.count = s_q.count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

module ump_uart #(
    parameter int RX_DEPTH = ump_pkg::RX_DEPTH
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic sfrRdEn,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrBitWrEn,
    input wire logic [7:0] sfrBitAddr,
    input wire logic sfrBitData,
    output logic [7:0] sfrRdData,
    input wire logic intEnable,
    output logic irqReq,
    input wire logic rxDone,
    input wire logic [7:0] rxData,
    input wire logic rxExtra,
    input wire logic rxStopOk,
    input wire logic rxStop1,
    output logic txValid,
    output logic [7:0] txData,
    output logic txExtraBit,
    input wire logic txTaken,
    input wire logic txStopStart
);
    // a buffer without slots could never hold a byte
    if (RX_DEPTH < 1) begin : g_bad_depth
        $error("ump_uart: receive depth must be at least one");
    end

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] fmt;
        logic [7:0] rdData;
        logic [7:0] rxLast;
        logic [7:0] txData;
        logic txValid;
        logic txExtra;
        logic irq;
        logic headSeen;
    } ump_state_s;

    ump_state_s s_q, s_d;
    logic [7:0] wMask, wVal, dlMask;
    logic rxAccept, fifoReady, fifoValid, pop, dataWr, pushErr, pushX;
    logic [9:0] fifoHead;

    // byte write or single-bit write into the control register
    assign wMask = (sfrWrEn && sfrAddr == ump_pkg::ADDR_CTRL) ? 8'hff :
        (sfrBitWrEn && sfrBitAddr[7:3] == ump_pkg::ADDR_CTRL[7:3]) ?
        (8'h01 << sfrBitAddr[2:0]) : 8'h00; // RQ14
    assign wVal = sfrWrEn ? sfrWrData : {8{sfrBitData}};

    // receive path: stop bits and enable decide storage
    assign rxAccept = rxDone && s_q.ctrl[ump_pkg::B_REN] && rxStopOk; // RQ7 RQ15
    assign dataWr = sfrWrEn && sfrAddr == ump_pkg::ADDR_DATA;
    assign pop = sfrRdEn && sfrAddr == ump_pkg::ADDR_DATA && fifoValid; // RQ16

    // parity over the configured data length, checked once the byte is oldest
    assign dlMask = 8'hff >> (2'h3 - s_q.fmt[ump_pkg::F_DL_LO +: 2]);
    always_comb begin
        logic par;
        par = ^(rxData & dlMask);
        unique case (s_q.fmt[ump_pkg::F_PT_LO +: 2])
            ump_pkg::PT_ODD: pushErr = (rxExtra == par);
            ump_pkg::PT_EVEN: pushErr = (rxExtra != par);
            ump_pkg::PT_MARK: pushErr = !rxExtra;
            ump_pkg::PT_SPACE: pushErr = rxExtra;
        endcase
    end
    // extra bit if enabled, else first stop level
    assign pushX = s_q.fmt[ump_pkg::F_XBE] ? rxExtra : rxStop1; // RQ9

    // a full buffer refuses the byte; that refusal becomes the overrun flag
    ump_fifo #(
        .WIDTH(ump_pkg::RX_WIDTH),
        .DEPTH(RX_DEPTH)
    ) rxFifo (
        .mclk(mclk),
        .reset(reset),
        .inValid(rxAccept),
        .inReady(fifoReady),
        .inData({pushErr, pushX, rxData}),
        .outValid(fifoValid),
        .outReady(pop),
        .outData(fifoHead)
    );

    // register file, flags and transmit holding register
    always_comb begin
        s_d = s_q;
        s_d.ctrl = (s_q.ctrl & ~(wMask & ump_pkg::CTRL_WMASK)) |
            (wVal & wMask & ump_pkg::CTRL_WMASK); // RQ18
        // software clear cannot drop the flag while bytes are waiting
        if (s_q.ctrl[ump_pkg::B_RI] && fifoValid) begin
            s_d.ctrl[ump_pkg::B_RI] = 1'b1; // RQ12
        end
        // hardware sets come last so a set beats a same-cycle clear
        if (rxAccept && !fifoReady) begin
            s_d.ctrl[ump_pkg::B_OVR] = 1'b1; // RQ4
        end
        if (rxAccept && fifoReady && (!s_q.fmt[ump_pkg::F_MCE] ||
            (s_q.fmt[ump_pkg::F_XBE] && rxExtra))) begin
            s_d.ctrl[ump_pkg::B_RI] = 1'b1; // RQ2 RQ11 RQ17
        end
        if (fifoValid && !s_q.headSeen && s_q.fmt[ump_pkg::F_PE] && fifoHead[9]) begin
            s_d.ctrl[ump_pkg::B_PERR] = 1'b1; // RQ5
        end
        s_d.headSeen = pop ? 1'b0 : fifoValid;
        if (fifoValid) begin
            s_d.ctrl[ump_pkg::B_RBX] = fifoHead[8]; // RQ9
        end
        if (txStopStart) begin
            s_d.ctrl[ump_pkg::B_TI] = 1'b1; // RQ10
        end
        // writes while the holding register is full are refused
        if (txTaken) begin
            s_d.txValid = 1'b0;
        end else if (dataWr && !s_q.txValid) begin
            s_d.txValid = 1'b1; // RQ6
            s_d.txData = sfrWrData;
            s_d.txExtra = s_q.fmt[ump_pkg::F_XBE] && !s_q.fmt[ump_pkg::F_PE] &&
                s_q.ctrl[ump_pkg::B_TBX]; // RQ8
        end
        // empty view tracks the holding register so a read never lags a write
        s_d.ctrl[ump_pkg::B_THRE] = !s_d.txValid; // RQ6
        if (pop) begin
            s_d.rxLast = fifoHead[7:0];
        end
        // read data appears one cycle after the strobe
        if (sfrRdEn) begin
            unique case (sfrAddr)
                ump_pkg::ADDR_CTRL: s_d.rdData = s_q.ctrl; // RQ6
                ump_pkg::ADDR_DATA: s_d.rdData = fifoValid ? fifoHead[7:0] : s_q.rxLast;
                ump_pkg::ADDR_FMT: s_d.rdData = s_q.fmt;
                default: s_d.rdData = 8'h00;
            endcase
        end
        if (sfrWrEn && sfrAddr == ump_pkg::ADDR_FMT) begin
            s_d.fmt = sfrWrData;
        end
        s_d.irq = intEnable && (s_d.ctrl[ump_pkg::B_TI] || s_d.ctrl[ump_pkg::B_RI]); // RQ13
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= '{ctrl: ump_pkg::CTRL_RESET, fmt: ump_pkg::FMT_RESET,
                rdData: ump_pkg::DATA_RESET, rxLast: ump_pkg::DATA_RESET,
                txData: ump_pkg::DATA_RESET, default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign sfrRdData = s_q.rdData;
    assign irqReq = s_q.irq;
    assign txValid = s_q.txValid;
    assign txData = s_q.txData;
    assign txExtraBit = s_q.txExtra;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_overrun_on_full: assert property (rxAccept && !fifoReady |=> s_q.ctrl[7]) // RQ4
        else $error("overrun flag not set on full buffer");
    a_mce_blocks_data: assert property (rxAccept && s_q.fmt[7] && !rxExtra // RQ2
        && !s_q.ctrl[0] && wMask == 8'h00 |=> !s_q.ctrl[0])
        else $error("data byte raised receive flag in multiproc mode");
    a_rx_avail_set: assert property (rxAccept && fifoReady && !s_q.fmt[7] // RQ11
        |=> s_q.ctrl[0] ##1 s_q.ctrl[0])
        else $error("receive flag not set on stored byte");
    a_rx_avail_hold: assert property (s_q.ctrl[0] && fifoValid |=> s_q.ctrl[0]) // RQ12
        else $error("receive flag cleared while bytes wait");
    a_ren_gates_rx: assert property (!s_q.ctrl[4] && rxDone && !fifoValid // RQ7
        |=> !fifoValid)
        else $error("byte stored while receive disabled");
    a_tx_done_set: assert property (txStopStart |=> s_q.ctrl[1]) // RQ10
        else $error("transmit done flag missed");
    a_thre_clears: assert property (sfrRdEn && sfrAddr == 8'h98 // RQ6
        |=> sfrRdData[5] == !$past(txValid))
        else $error("holding-empty view wrong on control read");
    a_tx_extra_bit: assert property (dataWr && !txValid && !txTaken // RQ8
        |=> txExtraBit == ($past(s_q.fmt[1]) && !$past(s_q.fmt[4]) && $past(s_q.ctrl[3])))
        else $error("transmitted extra bit wrong");
    a_perr_sticky: assert property (s_q.ctrl[6] && wMask[6] == 1'b0 |=> s_q.ctrl[6]) // RQ5
        else $error("parity error flag cleared by hardware");
    a_irq_follows: assert property ($rose(s_q.ctrl[1]) && $past(intEnable) |-> irqReq) // RQ13
        else $error("interrupt not requested on flag");
    a_pop_returns: assert property (pop |=> sfrRdData == $past(fifoHead[7:0])) // RQ16
        else $error("data read did not return oldest byte");
    a_bit_write: assert property (sfrBitWrEn && !sfrWrEn && sfrBitAddr == 8'h9b // RQ14
        |=> s_q.ctrl[3] == $past(sfrBitData))
        else $error("single-bit write missed");

    // parity, holding register, receive and interrupt views
    a_perr_on_head: assert property (fifoValid && !s_q.headSeen && fifoHead[9] // RQ5
        && s_q.fmt[4] |=> s_q.ctrl[6])
        else $error("parity error flag not set on bad oldest byte");
    a_tx_load: assert property (dataWr && !txValid && !txTaken // RQ6
        |=> txValid && txData == $past(sfrWrData))
        else $error("holding register not loaded by data write");
    a_tx_refused: assert property (dataWr && txValid |=> txData == $past(txData)) // RQ6
        else $error("data write accepted while holding register full");
    a_rx_extra_view: assert property (fifoValid |=> s_q.ctrl[2] == $past(fifoHead[8])) // RQ9
        else $error("extra receive bit does not follow oldest byte");
    a_stop_gate: assert property (rxDone && !rxStopOk && !fifoValid |=> !fifoValid) // RQ15
        else $error("byte with bad stop bit stored");
    a_irq_gated: assert property (!intEnable |=> !irqReq) // RQ13
        else $error("interrupt requested while disabled");

    // main scenarios the bench should reach
    c_overrun: cover property (rxAccept && !fifoReady);
    c_address_byte: cover property (rxAccept && s_q.fmt[7] && s_q.fmt[1] && rxExtra);
    c_tx_done: cover property (txStopStart ##1 irqReq);
    c_buffer_drain: cover property (pop ##1 pop);
    c_parity_error: cover property (fifoValid && s_q.fmt[4] && fifoHead[9]);
endmodule

`default_nettype wire

// ---- bench/ump_peer.sv ----
// far-side model: receive and transmit shifters of the serial line
`timescale 1ns/1ps
`default_nettype none
module ump_peer (
    input wire logic mclk,
    output var logic rxDone,
    output var logic [7:0] rxData,
    output var logic rxExtra,
    output var logic rxStopOk,
    output var logic rxStop1,
    input wire logic txValid,
    output var logic txTaken,
    output var logic txStopStart
);
    // quiet lines at time zero
    initial begin
        {rxDone, rxData, rxExtra, rxStopOk, rxStop1, txTaken, txStopStart} = '0;
    end
    // one frame ends; side lines flip after the pulse so stale values never match
    task automatic send(input logic [7:0] v, input logic x, input logic ok);
        @(posedge mclk);
        rxDone <= 1'b1;
        rxData <= v;
        rxExtra <= x;
        rxStopOk <= ok;
        rxStop1 <= ok;
        @(posedge mclk);
        rxDone <= 1'b0;
        rxData <= ~v;
        rxExtra <= ~x;
        rxStopOk <= ~ok;
        rxStop1 <= ~ok;
    endtask
    // shifter drains the holding register after a variable lag
    always begin
        @(posedge mclk);
        if (txValid === 1'b1) begin
            repeat (6 + $urandom_range(0, 3)) @(posedge mclk);
            txTaken <= 1'b1;
            @(posedge mclk);
            txTaken <= 1'b0;
            repeat (4) @(posedge mclk);
            txStopStart <= 1'b1;
            @(posedge mclk);
            txStopStart <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- bench/uart_multiproc_rx_status_test.sv ----
// self-checking bench of the serial port status and receive buffer
`timescale 1ns/1ps
`default_nettype none
module uart_multiproc_rx_status_test;
    logic mclk = 1'b0, reset = 1'b1, sfrWrEn = 1'b0, sfrRdEn = 1'b0, sfrBitWrEn = 1'b0;
    logic sfrBitData = 1'b0, intEnable = 1'b0, irqReq, rxDone, rxExtra, rxStopOk, rxStop1;
    logic txValid, txExtraBit, txTaken, txStopStart;
    logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrBitAddr = 8'h00;
    logic [7:0] sfrRdData, rxData, txData, d, x, m;
    logic [7:0] b [4];
    int error_cnt = 0, n_compared = 0, cycles = 0;
    always #2.5 mclk = ~mclk;
    ump_uart dut (.mclk(mclk), .reset(reset), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrBitWrEn(sfrBitWrEn),
        .sfrBitAddr(sfrBitAddr), .sfrBitData(sfrBitData), .sfrRdData(sfrRdData),
        .intEnable(intEnable), .irqReq(irqReq), .rxDone(rxDone), .rxData(rxData),
        .rxExtra(rxExtra), .rxStopOk(rxStopOk), .rxStop1(rxStop1), .txValid(txValid),
        .txData(txData), .txExtraBit(txExtraBit), .txTaken(txTaken),
        .txStopStart(txStopStart));
    ump_peer peer (.mclk(mclk), .rxDone(rxDone), .rxData(rxData), .rxExtra(rxExtra),
        .rxStopOk(rxStopOk), .rxStop1(rxStop1), .txValid(txValid), .txTaken(txTaken),
        .txStopStart(txStopStart));
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // bus tasks end at a falling edge so every update has landed
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        sfrAddr <= a;
        sfrWrData <= v;
        sfrWrEn <= 1'b1;
        @(posedge mclk);
        sfrWrEn <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic bw(input logic [7:0] a, input logic v);
        @(posedge mclk);
        sfrBitAddr <= a;
        sfrBitData <= v;
        sfrBitWrEn <= 1'b1;
        @(posedge mclk);
        sfrBitWrEn <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        sfrAddr <= a;
        sfrRdEn <= 1'b1;
        @(posedge mclk);
        sfrRdEn <= 1'b0;
        @(negedge mclk);
        d = sfrRdData;
    endtask
    function automatic logic par(input logic [7:0] v, input logic [1:0] t);
        case (t)
            ump_pkg::PT_ODD: return ~^v;
            ump_pkg::PT_EVEN: return ^v;
            ump_pkg::PT_MARK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    initial begin
        void'($urandom(32'h6462e8ad));
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        rd(8'h98);
        chk("ctrl", d, 8'h20);
        rd(8'ha9);
        chk("fmt", d, 8'h0c);
        rd(8'h50);
        chk("unmapped", d, 8'h00);
        wr(8'h98, 8'h00);
        bw(8'h9c, 1'b1);
        rd(8'h98);
        chk("ren", d, 8'h30);
        @(posedge mclk);
        intEnable <= 1'b1;
        // fourth byte overflows the three-deep buffer
        for (int i = 0; i < 4; i++) begin
            b[i] = 8'($urandom);
            peer.send(b[i], 1'b0, 1'b1);
        end
        bw(8'h98, 1'b0);
        rd(8'h98);
        chk("ovr", d & 8'h85, 8'h85);
        chk("irq", {7'h0, irqReq}, 8'h01);
        // interrupt enable off: request must drop though the flag stays
        @(posedge mclk);
        intEnable <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        chk("irqoff", {7'h0, irqReq}, 8'h00);
        @(posedge mclk);
        intEnable <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rd(8'h99);
            chk("pop", d, b[i]);
        end
        wr(8'h98, 8'h10);
        peer.send(b[3], 1'b0, 1'b0);
        rd(8'h98);
        chk("badstop", d, 8'h30);
        // receiver off: held byte still readable, new one dropped
        peer.send(b[1], 1'b0, 1'b1);
        bw(8'h9c, 1'b0);
        peer.send(b[2], 1'b0, 1'b1);
        rd(8'h99);
        chk("rxheld", d, b[1]);
        rd(8'h99);
        chk("rxoff", d, b[1]);
        bw(8'h98, 1'b0);
        bw(8'h9c, 1'b1);
        wr(8'ha9, 8'h82);
        peer.send(b[0], 1'b0, 1'b1);
        rd(8'h98);
        chk("mcedata", d & 8'h05, 8'h00);
        rd(8'h99);
        peer.send(b[1], 1'b1, 1'b1);
        rd(8'h98);
        chk("mceaddr", d & 8'h05, 8'h05);
        rd(8'h99);
        wr(8'ha9, 8'h02);
        bw(8'h98, 1'b0);
        peer.send(b[2], 1'b0, 1'b1);
        rd(8'h98);
        chk("slavedata", d & 8'h05, 8'h01);
        rd(8'h99);
        bw(8'h98, 1'b0);
        // every parity type and data length, wrong bit then right bit
        for (int t = 0; t < 4; t++) begin
            wr(8'ha9, {1'b0, 2'(t), 1'b1, 2'(t), 2'b00});
            x = 8'($urandom);
            m = 8'hff >> (3 - t);
            peer.send(x, ~par(x & m, 2'(t)), 1'b1);
            rd(8'h99);
            rd(8'h98);
            chk("perr", d & 8'h40, 8'h40);
            wr(8'h98, 8'h10);
            peer.send(x, par(x & m, 2'(t)), 1'b1);
            rd(8'h98);
            chk("pok", d & 8'h40, 8'h00);
            rd(8'h99);
            bw(8'h98, 1'b0);
        end
        wr(8'ha9, 8'h02);
        bw(8'h9b, 1'b1);
        x = 8'($urandom);
        wr(8'h99, x);
        chk("txd", txData, x);
        chk("txx", {7'h0, txExtraBit}, 8'h01);
        wr(8'h99, ~x);
        rd(8'h98);
        chk("full", d & 8'h22, 8'h00);
        chk("ignored", txData, x);
        for (int i = 0; i < 40 && d[1] !== 1'b1; i++) begin
            rd(8'h98);
        end
        chk("txdone", d & 8'h22, 8'h22);
        wr(8'ha9, 8'h12);
        wr(8'h99, x);
        chk("txpar", {7'h0, txExtraBit}, 8'h00);
        report_and_stop;
    end
endmodule
`default_nettype wire
